// File: hw/ssc_cfg.svh
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SSC_OFF_MW 8'h00
`define SSC_OFF_ADDR 8'h04
`define SSC_OFF_DATA 8'h08
`define SSC_OFF_STAT 8'h0c
`define SSC_OFF_RIDX 8'h10
`define SSC_OFF_BR 8'h14
// ----------------------------------------
// field positions
// ----------------------------------------
`define SSC_MW_BUSY_BIT 16
`define SSC_ADDR_EXT_BIT 12
`define SSC_DATA_UP_LSB 5
`define SSC_BR_MASK_LSB 12
`define SSC_STAT_SENSE_BIT 1
// ----------------------------------------
// reset values and responses
// ----------------------------------------
`define SSC_PROC_RST 1'b0
`define SSC_RESP_OK 2'b00
`define SSC_RESP_ERR 2'b10
// ----------------------------------------
// ring timing, in clock steps
// ----------------------------------------
`define SSC_RING_LONG 3'd4
`define SSC_RING_SHORT 3'd2
`endif

// File: hw/ssc_pkg.sv
package ssc_pkg;
  // microword, positions 1..9 held in bits 0..8
  typedef logic [8:0] ssc_mw_t;
  typedef logic [3:0] ssc_nib_t;
  typedef enum logic [1:0] {OP_NONE, OP_STORE, OP_SENSE, OP_CTL} ssc_op_e;
  typedef enum logic {RING_IDLE, RING_RUN} ssc_ring_e;
endpackage : ssc_pkg

// File: hw/ssc_ring.sv
`timescale 1ns/1ps
`include "ssc_cfg.svh"
module ssc_ring (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // control
  input wire logic start_in,
  input wire logic long_in,
  // timing pulses
  output logic busy_out,
  output logic first_out,
  output logic last_out
);
  import ssc_pkg::*;

  ssc_ring_e state_q;
  logic [2:0] cnt_q;
  logic [2:0] len_q;

  // last step depends on the cycle length taken at start
  assign busy_out = (state_q == RING_RUN);
  assign first_out = busy_out & (cnt_q == 3'd0);
  assign last_out = busy_out & (cnt_q == len_q - 3'd1);

  // ring advance, one step per enabled clock
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= RING_IDLE;
      cnt_q <= 3'd0;
      len_q <= `SSC_RING_SHORT;
    end else if (clk_en_in) begin
      case (state_q)
        RING_IDLE: begin
          if (start_in) begin
            state_q <= RING_RUN;
            cnt_q <= 3'd0;
            len_q <= long_in ? `SSC_RING_LONG : `SSC_RING_SHORT;
          end
        end
        RING_RUN: begin
          if (last_out) begin
            state_q <= RING_IDLE;
          end else begin
            cnt_q <= cnt_q + 3'd1;
          end
        end
        default: state_q <= RING_IDLE;
      endcase
    end
  end
endmodule : ssc_ring

// File: hw/ssc_decode.sv
// How it works
// - store writes upper and lower data byte
// - twelve address bits from high, mid, low
// - extended bit joins address latch for 8K
// - gate 3 with position 1 low routes address
// - store decode yields start and write pulses
// - storage start loads address latch
// - start write drives decoded address, writes byte
// - position 5 picks long or short cycle
// - 64 sense addresses, four indicator bits
// - sense decode sets the sense latch
// - sense field positions weight 32 down to 1
// - high three bits group, low three gate
// - active indicators raise bus lines 1,2,4,8
// - each line may sense inverted indicator
// - parity generated from bus latch when sensing
// - clock C reloads lower register unchanged
// - 32 control addresses from five positions
// - conditional control needs a data bit
// - control 0 clears the process latch
// - control decode, position 4 picks half
// - position 5 with decoders picks action
// - zero-mask return branch ORs in return index
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "ssc_cfg.svh"
module ssc_decode #(
  parameter logic [255:0] SENSE_INVERT = 256'h0,
  parameter logic [31:0] CTL_COND = 32'h0,
  parameter logic [95:0] CTL_TEST_BIT = 96'h0
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // axi4-lite write channels
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // axi4-lite read channels
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // indicator pins, four per sense address
  input wire logic [255:0] indicators_in,
  // main storage side
  output logic [12:0] storage_address_latch_out,
  output logic [9:0] mem_data_out,
  output logic mem_start_out,
  output logic mem_write_out,
  // control actions and status
  output logic [31:0] ctl_action_out,
  output logic process_run_out,
  output logic busy_out
);
  import ssc_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [255:0] ind_meta_q;
  logic [255:0] ind_sync_q;
  ssc_mw_t microword_data_reg_q;
  ssc_nib_t address_high_reg_q;
  ssc_nib_t address_mid_reg_q;
  ssc_nib_t address_low_reg_q;
  logic extended_address_reg_q;
  logic [4:0] lower_data_reg_q;
  logic [4:0] upper_data_reg_q;
  ssc_nib_t return_index_reg_q;
  logic [11:0] br_base_q;
  ssc_nib_t br_mask_q;
  logic [12:0] addr_latch_q;
  ssc_nib_t bus_latch_q;
  logic sense_latch_q;
  logic process_q;
  logic [31:0] ctl_q;
  logic mem_start_q;
  logic mem_write_q;
  logic go_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // gate decoder: positions 7,8,9 as a 0-7 number
  function automatic logic [2:0] gate_of(input ssc_mw_t w);
    return {w[6], w[7], w[8]};
  endfunction : gate_of

  // odd parity over a nibble
  function automatic logic odd_par(input ssc_nib_t d);
    return ~^d;
  endfunction : odd_par

  // byte-lane merge for partial writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  // ----------------------------------------
  // microword decode
  // ----------------------------------------
  logic [9:1] p;
  logic is_store;
  logic is_sense;
  logic is_ctl;
  ssc_op_e op;
  logic [2:0] gate;
  logic gate3_sel;
  ssc_nib_t bus_low;

  assign p = microword_data_reg_q;
  assign gate = gate_of(microword_data_reg_q);
  assign is_store = ~p[1] & ~p[2] & p[3] & ~p[4] & ~p[6];
  assign is_sense = ~p[1] & p[2] & p[6];
  assign is_ctl = ~p[1] & ~p[2] & p[3] & p[6];
  assign op = is_store ? OP_STORE :
              is_sense ? OP_SENSE :
              is_ctl ? OP_CTL : OP_NONE;
  // low address rides the bus only under gate 3 with position 1 low
  assign gate3_sel = (gate == 3'd3) & ~p[1];
  assign bus_low = gate3_sel ? address_low_reg_q : 4'h0;

  // ----------------------------------------
  // sense path
  // ----------------------------------------
  logic [5:0] sense_addr;
  logic [7:0] group_sel;
  logic [7:0] ind_base;
  ssc_nib_t ind_raw;
  ssc_nib_t sense_bus;

  assign sense_addr = {p[3], p[4], p[5], p[7], p[8], p[9]};
  assign group_sel = is_sense ? (8'h01 << sense_addr[5:3]) : 8'h00;
  assign ind_base = {sense_addr, 2'b00};
  // polarity per line trades a pin inverter for a table
  assign ind_raw = ind_sync_q[ind_base +: 4] ^ SENSE_INVERT[ind_base +: 4];
  assign sense_bus = ind_raw & {4{|group_sel}};

  // ----------------------------------------
  // control path
  // ----------------------------------------
  logic [4:0] ctl_addr;
  logic [6:0] ctl_tb_idx;
  logic [2:0] ctl_test;
  logic [7:0] data8;
  logic ctl_ok;
  logic [31:0] ctl_sel;

  assign ctl_addr = {p[4], p[5], gate};
  assign ctl_tb_idx = 7'(ctl_addr) * 7'd3;
  assign ctl_test = CTL_TEST_BIT[ctl_tb_idx +: 3];
  assign data8 = {upper_data_reg_q[3:0], lower_data_reg_q[3:0]};
  assign ctl_ok = ~CTL_COND[ctl_addr] | data8[ctl_test];
  assign ctl_sel = (is_ctl & ctl_ok) ? (32'h1 << ctl_addr) : 32'h0;

  // ----------------------------------------
  // ring timing
  // ----------------------------------------
  logic ring_busy;
  logic ring_first;
  logic ring_last;

  ssc_ring u_ring (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .start_in(go_q),
    .long_in(is_store & p[5]),
    .busy_out(ring_busy),
    .first_out(ring_first),
    .last_out(ring_last)
  );

  assign busy_out = go_q | ring_busy;

  // ----------------------------------------
  // return branch
  // ----------------------------------------
  logic [11:0] next_microaddress;
  assign next_microaddress = (br_mask_q == 4'h0) ?
      {br_base_q[11:4], br_base_q[3:0] | return_index_reg_q} :
      br_base_q;

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  logic aw_fire;
  logic ar_fire;
  logic [31:0] wmerge;
  logic [31:0] wmerge_br;
  logic wr_mw;
  logic wr_addr;
  logic wr_data;
  logic wr_stat;
  logic wr_ridx;
  logic wr_br;
  logic w_hit;

  // read mux, shared by reads and partial-write merges
  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    case ({a[7:2], 2'b00})
      `SSC_OFF_MW: begin
        v[8:0] = microword_data_reg_q;
        v[`SSC_MW_BUSY_BIT] = busy_out;
      end
      `SSC_OFF_ADDR: begin
        v[11:0] = {address_high_reg_q, address_mid_reg_q,
                   address_low_reg_q};
        v[`SSC_ADDR_EXT_BIT] = extended_address_reg_q;
      end
      `SSC_OFF_DATA: v[9:0] = {upper_data_reg_q, lower_data_reg_q};
      `SSC_OFF_STAT: begin
        v[0] = process_q;
        v[`SSC_STAT_SENSE_BIT] = sense_latch_q;
      end
      `SSC_OFF_RIDX: v[3:0] = return_index_reg_q;
      `SSC_OFF_BR: begin
        v[11:0] = next_microaddress;
        v[`SSC_BR_MASK_LSB +: 4] = br_mask_q;
      end
      default: v = 32'h0;
    endcase
    return v;
  endfunction : reg_read

  // both write channels are taken together on one edge
  assign aw_fire = s_axi_awvalid_in & s_axi_wvalid_in & ~bvalid_q & clk_en_in;
  assign ar_fire = s_axi_arvalid_in & ~rvalid_q & clk_en_in;
  assign s_axi_awready_out = aw_fire;
  assign s_axi_wready_out = aw_fire;
  assign s_axi_arready_out = ar_fire;
  assign wmerge = lane_merge(reg_read(s_axi_awaddr_in), s_axi_wdata_in,
                             s_axi_wstrb_in);
  // branch reads show the merged address, so keep lanes from the stored base
  assign wmerge_br = lane_merge({16'h0, br_mask_q, br_base_q},
                                s_axi_wdata_in, s_axi_wstrb_in);
  // a microword write during an operation is dropped, answer stays okay
  assign wr_mw = aw_fire & ({s_axi_awaddr_in[7:2], 2'b00} == `SSC_OFF_MW) &
                 ~busy_out;
  assign wr_addr = aw_fire & ({s_axi_awaddr_in[7:2], 2'b00} == `SSC_OFF_ADDR);
  assign wr_data = aw_fire & ({s_axi_awaddr_in[7:2], 2'b00} == `SSC_OFF_DATA);
  assign wr_stat = aw_fire & ({s_axi_awaddr_in[7:2], 2'b00} == `SSC_OFF_STAT);
  assign wr_ridx = aw_fire & ({s_axi_awaddr_in[7:2], 2'b00} == `SSC_OFF_RIDX);
  assign wr_br = aw_fire & ({s_axi_awaddr_in[7:2], 2'b00} == `SSC_OFF_BR);
  assign w_hit = s_axi_awaddr_in[7:2] <= 6'd5;

  // responses
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      bvalid_q <= 1'b0;
      bresp_q <= `SSC_RESP_OK;
      rvalid_q <= 1'b0;
      rresp_q <= `SSC_RESP_OK;
      rdata_q <= 32'h0;
    end else if (clk_en_in) begin
      if (aw_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= w_hit ? `SSC_RESP_OK : `SSC_RESP_ERR;
      end else if (s_axi_bready_in) begin
        bvalid_q <= 1'b0;
      end
      if (ar_fire) begin
        rvalid_q <= 1'b1;
        rdata_q <= reg_read(s_axi_araddr_in);
        rresp_q <= (s_axi_araddr_in[7:2] <= 6'd5) ?
                   `SSC_RESP_OK : `SSC_RESP_ERR;
      end else if (s_axi_rready_in) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rresp_out = rresp_q;
  assign s_axi_rdata_out = rdata_q;

  // ----------------------------------------
  // indicator synchroniser
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ind_meta_q <= 256'h0;
      ind_sync_q <= 256'h0;
    end else if (clk_en_in) begin
      ind_meta_q <= indicators_in;
      ind_sync_q <= ind_meta_q;
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      microword_data_reg_q <= 9'h000;
      go_q <= 1'b0;
      address_high_reg_q <= 4'h0;
      address_mid_reg_q <= 4'h0;
      address_low_reg_q <= 4'h0;
      extended_address_reg_q <= 1'b0;
      return_index_reg_q <= 4'h0;
      br_base_q <= 12'h000;
      br_mask_q <= 4'h0;
    end else if (clk_en_in) begin
      go_q <= wr_mw;
      if (wr_mw) begin
        microword_data_reg_q <= wmerge[8:0];
      end
      if (wr_addr) begin
        {address_high_reg_q, address_mid_reg_q, address_low_reg_q} <=
            wmerge[11:0];
        extended_address_reg_q <= wmerge[`SSC_ADDR_EXT_BIT];
      end
      if (wr_ridx) begin
        return_index_reg_q <= wmerge[3:0];
      end
      if (wr_br) begin
        br_base_q <= wmerge_br[11:0];
        br_mask_q <= wmerge_br[`SSC_BR_MASK_LSB +: 4];
      end
    end
  end

  // ----------------------------------------
  // data registers: the sense reload beats software
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      lower_data_reg_q <= 5'h00;
      upper_data_reg_q <= 5'h00;
    end else if (clk_en_in) begin
      if (sense_latch_q & ring_last) begin
        // modifier passes parity and bus bits unchanged
        lower_data_reg_q <= {odd_par(bus_latch_q), bus_latch_q};
      end else if (wr_data) begin
        lower_data_reg_q <= wmerge[4:0];
      end
      if (wr_data) begin
        upper_data_reg_q <= wmerge[`SSC_DATA_UP_LSB +: 5];
      end
    end
  end

  // ----------------------------------------
  // operation sequencing
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      addr_latch_q <= 13'h0000;
      bus_latch_q <= 4'h0;
      sense_latch_q <= 1'b0;
      mem_start_q <= 1'b0;
      mem_write_q <= 1'b0;
      ctl_q <= 32'h0;
    end else if (clk_en_in) begin
      mem_start_q <= (op == OP_STORE) & ring_first;
      mem_write_q <= (op == OP_STORE) & ring_last;
      ctl_q <= ring_last ? ctl_sel : 32'h0;
      if ((op == OP_STORE) & ring_first) begin
        addr_latch_q <= {extended_address_reg_q, address_high_reg_q,
                         address_mid_reg_q, bus_low};
      end
      if ((op == OP_SENSE) & ring_first) begin
        bus_latch_q <= sense_bus;
        sense_latch_q <= 1'b1;
      end else if (ring_last) begin
        sense_latch_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // process latch: the stop action beats a software start
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      process_q <= `SSC_PROC_RST;
    end else if (clk_en_in) begin
      if (ctl_q[0]) begin
        process_q <= 1'b0;
      end else if (wr_stat & wmerge[0]) begin
        process_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign storage_address_latch_out = addr_latch_q;
  // stored byte is upper then lower, parity bits included
  assign mem_data_out = {upper_data_reg_q, lower_data_reg_q};
  assign mem_start_out = mem_start_q;
  assign mem_write_out = mem_write_q;
  assign ctl_action_out = ctl_q;
  assign process_run_out = process_q;
endmodule : ssc_decode

// File: test/ssc_decode_sva.sv
`timescale 1ns/1ps
module ssc_decode_sva #(
  parameter logic [31:0] CTL_COND = 32'h0
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // bus write side
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  // operation side
  input wire logic mem_start_out,
  input wire logic mem_write_out,
  input wire logic [31:0] ctl_action_out,
  input wire logic process_run_out,
  input wire logic busy_out
);
  // ----------------------------------------
  // word decode
  // ----------------------------------------
  // a word only starts while idle; busy words are dropped
  wire logic hit = s_axi_awvalid_in && s_axi_awready_out;
  wire logic go = hit && s_axi_awaddr_in[7:2] == 6'h0 && !busy_out;
  wire logic [8:0] w = s_axi_wdata_in[8:0];
  wire logic st = w[2:0] == 3'b100 && !w[3] && !w[5];
  wire logic sn = w[1:0] == 2'b10 && w[5];
  wire logic ct = w[2:0] == 3'b100 && w[5];
  wire logic [4:0] ca = {w[3], w[4], w[6], w[7], w[8]};
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // ----------------------------------------
  // sequences and properties
  // ----------------------------------------
  sequence short_go;
    go && st && !w[4];
  endsequence
  sequence long_go;
    go && st && w[4];
  endsequence
  // address latched at the take, checked four edges on
  property act_p;
    logic [4:0] c;
    (go && ct && !CTL_COND[ca], c = ca) |-> ##4 ctl_action_out == 32'h1 << c;
  endproperty
  st_start_a: assert property (go && st |-> ##3 mem_start_out)
    else $error("store start pulse missing");
  short_wr_a: assert property (short_go |-> ##4 mem_write_out)
    else $error("short store write pulse missing");
  long_wr_a: assert property (
    long_go |-> ##1 !mem_write_out [*5] ##1 mem_write_out)
    else $error("long store write pulse misplaced");
  wr_after_a: assert property (
    mem_write_out |-> $past(mem_start_out) || $past(mem_start_out, 3))
    else $error("write pulse without storage start");
  ctl_act_a: assert property (act_p)
    else $error("control action wrong or missing");
  ctl_onehot_a: assert property ($onehot0(ctl_action_out))
    else $error("more than one control action");
  ctl_stop_a: assert property (ctl_action_out[0] |=> !process_run_out)
    else $error("control zero left process latch set");
  sense_quiet_a: assert property (
    go && sn |-> ##1 (!mem_start_out && ctl_action_out == 32'h0) [*4])
    else $error("sense word touched storage or control");
  go_busy_a: assert property (go |=> busy_out)
    else $error("accepted word not busy");
endmodule : ssc_decode_sva

bind ssc_decode ssc_decode_sva #(.CTL_COND(CTL_COND)) ssc_decode_sva_i (
  .clk_in(clk_in),
  .reset_in(reset_in),
  .s_axi_awaddr_in(s_axi_awaddr_in),
  .s_axi_awvalid_in(s_axi_awvalid_in),
  .s_axi_awready_out(s_axi_awready_out),
  .s_axi_wdata_in(s_axi_wdata_in),
  .mem_start_out(mem_start_out),
  .mem_write_out(mem_write_out),
  .ctl_action_out(ctl_action_out),
  .process_run_out(process_run_out),
  .busy_out(busy_out)
);

// File: test/ssc_far_model.sv
`timescale 1ns/1ps
module ssc_far_model (
  // clock
  input wire logic clk_in,
  // storage side
  input wire logic [12:0] addr_in,
  input wire logic [9:0] data_in,
  input wire logic write_in,
  // indicator circuits
  input wire logic [255:0] level_in,
  output logic [255:0] indicators_out
);
  // ----------------------------------------
  // main storage, 8k bytes of 10 bits
  // ----------------------------------------
  logic [9:0] mem_q [0:8191];
  // byte lands at the latched address on the write pulse
  always @(posedge clk_in) begin
    if (write_in === 1'b1) begin
      mem_q[addr_in] <= data_in;
    end
  end
  // indicators are free-running levels set by the bench
  assign indicators_out = level_in;
endmodule : ssc_far_model

// File: test/test_store_sense_control_microop_decode.sv
`timescale 1ns/1ps
`include "ssc_cfg.svh"
module test_store_sense_control_microop_decode;
  import ssc_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk_in = 0, reset_in = 1;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, act;
  logic awvalid = 0, wvalid = 0, arvalid = 0;
  logic clk_en = 1, bready = 0, rready = 0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, mstart, mwrite, run, busy;
  logic [1:0] bresp, rresp;
  logic [255:0] lvl = 0, ind;
  logic [12:0] sal, ad;
  logic [9:0] mdat, dd;
  logic [3:0] nib;
  logic [65:0] t;
  logic [5:0] sa [4] = '{6'd0, 6'd1, 6'd43, 6'd63};
  logic [4:0] ca [3] = '{5'd1, 5'd16, 5'd31};
  int bad_count = 0, checked = 0, seed = 25608, n;
  logic [1:0] b_q [$];
  logic [65:0] r_q [$];
  logic [22:0] w_q [$];
  logic [31:0] c_q [$];
  always #5 clk_in = ~clk_in;
  // address 1 senses inverted lines; control 12 tests lower bit 2
  ssc_decode #(.SENSE_INVERT(256'hf0), .CTL_COND(32'h1000),
    .CTL_TEST_BIT(96'h2000000000)) ssc_decode_i (
    .clk_in(clk_in), .reset_in(reset_in), .clk_en_in(clk_en),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .indicators_in(ind),
    .storage_address_latch_out(sal), .mem_data_out(mdat),
    .mem_start_out(mstart), .mem_write_out(mwrite),
    .ctl_action_out(act), .process_run_out(run), .busy_out(busy));
  ssc_far_model ssc_far_model_i (.clk_in(clk_in), .addr_in(sal),
    .data_in(mdat), .write_in(mwrite), .level_in(lvl),
    .indicators_out(ind));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task stop_test;
    if (bad_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  task chk(input string s, input logic [65:0] e, input logic [65:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // a wait that runs out ends the run
  task tmo;
    if (n >= 200) begin
      bad_count++;
      stop_test();
    end
  endtask : tmo
  function automatic logic [31:0] mw(logic [5:0] a, logic p6, logic p2);
    return {23'h0, a[0], a[1], a[2], p6, a[3], a[4], a[5], p2, 1'b0};
  endfunction : mw
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    b_q.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    n = 0;
    do @(posedge clk_in); while ((awready & wready) !== 1'b1 && ++n < 200);
    tmo();
    awvalid <= 0;
    wvalid <= 0;
    // sometimes late with bready, so the response has to stand
    if ($random(seed) & 1) @(posedge clk_in);
    bready <= 1;
    n = 0;
    do @(posedge clk_in); while ((bvalid & bready) !== 1'b1 && ++n < 200);
    tmo();
    bready <= 0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
      input logic [1:0] r);
    r_q.push_back({r, m, e});
    araddr <= a;
    arvalid <= 1;
    n = 0;
    do @(posedge clk_in); while (arready !== 1'b1 && ++n < 200);
    tmo();
    arvalid <= 0;
    rready <= 1;
    n = 0;
    do @(posedge clk_in); while ((rvalid & rready) !== 1'b1 && ++n < 200);
    tmo();
    rready <= 0;
  endtask : rd
  task op(input logic [5:0] a, input logic p6, input logic p2);
    wr(`SSC_OFF_MW, mw(a, p6, p2), `SSC_RESP_OK);
    n = 0;
    do @(posedge clk_in); while (busy !== 1'b0 && ++n < 200);
    tmo();
  endtask : op
  // ----------------------------------------
  // watcher: oldest note against each result
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (bvalid === 1'b1 && bready === 1'b1)
      chk("bresp", b_q.size() ? b_q.pop_front() : 'x, bresp);
    if (rvalid === 1'b1 && rready === 1'b1) begin
      t = r_q.size() ? r_q.pop_front() : {2'b11, 64'h0};
      chk("read", t, {rresp, t[63:32], rdata & t[63:32]});
    end
    if (mwrite === 1'b1) chk("store", w_q.size() ? w_q.pop_front() : 'x,
      {sal, mdat});
    if (act !== 32'h0) chk("action", c_q.size() ? c_q.pop_front() : 'x, act);
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk_in);
    reset_in <= 0;
    @(posedge clk_in);
    chk("run", 66'h0, run);
    rd(`SSC_OFF_STAT, 32'h0, 32'h3, `SSC_RESP_OK);
    rd(8'h18, 32'h0, 32'hffffffff, `SSC_RESP_ERR);
    wr(8'h18, 32'h1, `SSC_RESP_ERR);
    // stores, short and long, gate 3 and another gate
    for (int i = 0; i < 5; i++) begin
      ad = $random(seed);
      dd = $random(seed);
      wr(`SSC_OFF_ADDR, {19'h0, ad}, `SSC_RESP_OK);
      wr(`SSC_OFF_DATA, {22'h0, dd}, `SSC_RESP_OK);
      w_q.push_back({ad[12:4], i[1] ? 4'h0 : ad[3:0], dd});
      op({2'b10, i[0], i[1] ? 3'd5 : 3'd3}, 0, 0);
    end
    // sense groups, edge addresses, one inverted
    for (int k = 0; k < 8; k++) lvl[32 * k +: 32] <= $random(seed);
    repeat (4) @(posedge clk_in);
    foreach (sa[k]) begin
      nib = lvl[4 * sa[k] +: 4] ^ (sa[k] == 6'd1 ? 4'hf : 4'h0);
      op(sa[k], 1, 1);
      rd(`SSC_OFF_DATA, {27'h0, ~^nib, nib}, 32'h1f, `SSC_RESP_OK);
    end
    // control actions; a word sent while busy is dropped
    wr(`SSC_OFF_STAT, 32'h1, `SSC_RESP_OK);
    rd(`SSC_OFF_STAT, 32'h1, 32'h1, `SSC_RESP_OK);
    foreach (ca[k]) begin
      c_q.push_back(32'h1 << ca[k]);
      op({1'b1, ca[k]}, 1, 0);
    end
    // lower half now holds the last sensed nibble and its parity
    w_q.push_back({ad[12:4], ad[3:0], dd[9:5], ~^nib, nib});
    wr(`SSC_OFF_MW, mw(6'h2b, 0, 0), `SSC_RESP_OK);
    op(6'h25, 1, 0);
    wr(`SSC_OFF_DATA, 32'h4, `SSC_RESP_OK);
    c_q.push_back(32'h1000);
    op(6'h2c, 1, 0);
    wr(`SSC_OFF_DATA, 32'h0, `SSC_RESP_OK);
    op(6'h2c, 1, 0);
    c_q.push_back(32'h1);
    op(6'h20, 1, 0);
    rd(`SSC_OFF_STAT, 32'h0, 32'h1, `SSC_RESP_OK);
    chk("run", 66'h0, run);
    // return branch: zero mask merges return index
    // frozen clock enable: the write waits until the enable returns
    clk_en <= 0;
    fork
      wr(`SSC_OFF_RIDX, 32'h5, `SSC_RESP_OK);
      begin
        repeat (3) @(posedge clk_in);
        chk("frozen", 66'h0, {awready, bvalid});
        clk_en <= 1;
      end
    join
    wr(`SSC_OFF_BR, 32'h03a3, `SSC_RESP_OK);
    rd(`SSC_OFF_BR, 32'h03a7, 32'hffff, `SSC_RESP_OK);
    // only the mask byte is written, the base lane is kept
    wstrb <= 4'h2;
    wr(`SSC_OFF_BR, 32'h33ff, `SSC_RESP_OK);
    wstrb <= 4'hf;
    rd(`SSC_OFF_BR, 32'h33a3, 32'hffff, `SSC_RESP_OK);
    repeat (4) @(posedge clk_in);
    chk("left", 66'h0, b_q.size() + r_q.size() + w_q.size() + c_q.size());
    stop_test();
  end
endmodule : test_store_sense_control_microop_decode
